// *** emf_mode_ctrl.sv ***
/*
  Mode management core of a managed flash device: firmware update mode,
  power-off and sleep notification byte, write cache control and enhanced
  user area sizing. Commands arrive from the link clock domain through
  emf_cmd_link; busy is sent back to drive DAT0 low.
  Assumes ref_clk at 10 MHz, a synchronous active-low reset_n for power-up
  and an asynchronous hardware reset pin hw_rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
`include "emf_defines.svh"

module emf_mode_ctrl #(
  parameter logic [31:0] UPDATE_ARG = 32'h0000_0100,
  parameter logic MODE_OPS_SUPPORTED = 1'b0,
  parameter logic [7:0] GENERIC_SWITCH_TIME = 8'h0a,
  parameter logic [7:0] LONG_OFF_TIME = 8'h14,
  parameter logic [7:0] SLEEP_NOTICE_TIME = 8'h0a
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hw_rst_n,
  input wire logic link_clk,
  input wire logic cmd_i,
  output logic dat0_o,
  output logic dat0_oe,
  input wire logic [23:0] enhanced_multiplier,
  input wire logic [23:0] max_enhanced_multiplier,
  input wire logic [7:0] protect_group_size,
  input wire logic [7:0] erase_group_size,
  output logic busy,
  output logic cache_enabled,
  output logic flush_active,
  output logic [7:0] power_down_notice,
  output logic [7:0] sleep_notice_busy_limit,
  output logic in_field_code_update,
  output logic [15:0] fw_sectors_programmed,
  output logic fw_install,
  output logic fw_abort,
  output logic switch_error,
  output logic update_arg_error,
  output logic sleeping,
  output logic [48:0] enhanced_area_kb,
  output logic [48:0] max_enhanced_area_kb
);

  localparam logic [31:0] GEN_LIMIT_CYC = 32'(GENERIC_SWITCH_TIME) * `EMF_TIMEOUT_UNIT_CYC;
  localparam logic [31:0] LONG_LIMIT_CYC = 32'(LONG_OFF_TIME) * `EMF_TIMEOUT_UNIT_CYC;
  localparam logic [31:0] SLEEP_LIMIT_CYC = 32'(`EMF_SLEEP_UNIT_CYC) << SLEEP_NOTICE_TIME;

  function automatic logic [7:0] emf_apply(
    input logic [7:0] old,
    input logic [7:0] val,
    input logic [1:0] acc
  );
    case (acc)
      `EMF_ACC_SET: emf_apply = old | val;
      `EMF_ACC_CLR: emf_apply = old & ~val;
      `EMF_ACC_WRITE: emf_apply = val;
      default: emf_apply = old;
    endcase
  endfunction

  function automatic logic [48:0] emf_area_kb(
    input logic [23:0] mult,
    input logic [7:0] wp,
    input logic [7:0] er
  );
    emf_area_kb = 49'(mult) * 49'(wp) * 49'(er) * `EMF_AREA_UNIT_KB;
  endfunction

  function automatic logic [23:0] emf_min_cyc(
    input logic [31:0] a,
    input logic [31:0] b
  );
    emf_min_cyc = (a < b) ? a[23:0] : b[23:0];
  endfunction

  logic [5:0] cmd_idx;
  logic [31:0] cmd_arg;
  logic cmd_tog;
  logic busy_core;
  logic cmd_ev;
  logic rst_ev;
  logic sw_ok;
  logic restore_hit;
  logic dl_cmd;
  logic [7:0] sw_idx;
  logic [7:0] sw_new_mode;
  logic [7:0] sw_new_cache;
  logic [7:0] sw_new_notice;

  emf_pkg::emf_core_t q;
  emf_pkg::emf_core_t d;

  emf_cmd_link u_link (
    .link_clk(link_clk),
    .reset_n(reset_n),
    .cmd_i(cmd_i),
    .busy_core(busy_core),
    .dat0_o(dat0_o),
    .dat0_oe(dat0_oe),
    .cmd_idx(cmd_idx),
    .cmd_arg(cmd_arg),
    .cmd_tog(cmd_tog)
  );

  // Only the second and third toggle stages are compared; the first one is
  // left alone so that a metastable sample never reaches the edge detector.
  assign cmd_ev = q.tog[1] ^ q.tog[2];
  assign rst_ev = !q.hrs[1] || (cmd_ev && cmd_idx == `EMF_CMD_RESET);
  assign sw_ok = cmd_ev && cmd_idx == `EMF_CMD_SWITCH && q.st == emf_pkg::emf_st_ready;
  assign sw_idx = cmd_arg[23:16];
  assign sw_new_mode = emf_apply(q.mode, cmd_arg[15:8], cmd_arg[25:24]);
  assign sw_new_cache = emf_apply({7'h00, q.cache_en}, cmd_arg[15:8], cmd_arg[25:24]);
  assign sw_new_notice = emf_apply(q.notice, cmd_arg[15:8], cmd_arg[25:24]);
  assign dl_cmd = cmd_ev && (cmd_idx == `EMF_CMD_RD_SINGLE || cmd_idx == `EMF_CMD_RD_MULTI ||
                             cmd_idx == `EMF_CMD_WR_SINGLE || cmd_idx == `EMF_CMD_WR_MULTI);
  // Select and sleep are the sequence that follows a sleep notice, so they are
  // the only commands that leave that code in place.
  assign restore_hit = cmd_ev &&
                       (q.notice == `EMF_NOTICE_SHORT || q.notice == `EMF_NOTICE_LONG ||
                        (q.notice == `EMF_NOTICE_SLEEP && cmd_idx != `EMF_CMD_SLEEP &&
                         cmd_idx != `EMF_CMD_SELECT));

  always_comb begin
    d = q;
    d.tog = {q.tog[1:0], cmd_tog};
    d.hrs = {q.hrs[0], hw_rst_n};
    d.install = 1'b0;
    d.abort = 1'b0;
    d.enh = emf_area_kb(enhanced_multiplier, protect_group_size, erase_group_size);
    d.enh_max = emf_area_kb(max_enhanced_multiplier, protect_group_size, erase_group_size);
    d.run = (q.st == emf_pkg::emf_st_busy) ? q.run + 32'h1 : 32'h0;
    if (q.st == emf_pkg::emf_st_busy) begin
      if (q.cnt <= 24'h1) begin
        d.st = emf_pkg::emf_st_ready;
        d.flush = 1'b0;
      end else begin
        d.cnt = q.cnt - 24'h1;
      end
    end
    if (rst_ev) begin
      d.st = emf_pkg::emf_st_ready;
      d.kind = emf_pkg::emf_bk_switch;
      d.cnt = 24'h0;
      d.cache_en = 1'b0;
      d.flush = 1'b0;
      d.notice = `EMF_NOTICE_NONE;
      d.used = 1'b0;
      d.mode = `EMF_MODE_NORMAL;
      d.dl = 1'b0;
      d.sectors = 16'h0000;
      d.sw_err = 1'b0;
      d.arg_bad = 1'b0;
      if (q.mode == `EMF_MODE_UPDATE && q.dl) begin
        d.abort = 1'b1;
      end else if (q.sectors != 16'h0000 && !MODE_OPS_SUPPORTED) begin
        d.install = 1'b1;
      end
    end else if (cmd_ev) begin
      if (restore_hit) begin
        // A command during the notice work ends that work early; select and sleep do not end sleep notice work.
        d.notice = `EMF_NOTICE_ON;
        if (q.st == emf_pkg::emf_st_busy && q.kind != emf_pkg::emf_bk_flush) begin
          d.st = emf_pkg::emf_st_ready;
        end
      end
      if (sw_ok) begin
        d.sw_err = 1'b0;
        if (sw_idx == `EMF_IDX_MODE_CFG) begin
          d.mode = sw_new_mode;
          if (sw_new_mode == `EMF_MODE_NORMAL && q.dl) begin
            d.dl = 1'b0;
            d.abort = 1'b1;
          end
          d.st = emf_pkg::emf_st_busy;
          d.kind = emf_pkg::emf_bk_switch;
          d.cnt = 24'(`EMF_SWITCH_CYC);
        end else if (sw_idx == `EMF_IDX_CACHE) begin
          d.cache_en = sw_new_cache[0];
          d.st = emf_pkg::emf_st_busy;
          if (q.cache_en && !sw_new_cache[0]) begin
            d.flush = 1'b1;
            d.kind = emf_pkg::emf_bk_flush;
            d.cnt = 24'(`EMF_FLUSH_CYC);
          end else begin
            d.kind = emf_pkg::emf_bk_switch;
            d.cnt = 24'(`EMF_SWITCH_CYC);
          end
        end else if (sw_idx == `EMF_IDX_NOTICE) begin
          if (sw_new_notice == `EMF_NOTICE_NONE && q.used) begin
            d.sw_err = 1'b1;
            d.notice = q.notice;
          end else begin
            d.notice = sw_new_notice;
            d.used = q.used || sw_new_notice != `EMF_NOTICE_NONE;
            d.st = emf_pkg::emf_st_busy;
            unique case (sw_new_notice)
              `EMF_NOTICE_SHORT: begin
                d.kind = emf_pkg::emf_bk_short;
                d.cnt = emf_min_cyc(32'(`EMF_SHORT_CYC), GEN_LIMIT_CYC);
              end
              `EMF_NOTICE_LONG: begin
                d.kind = emf_pkg::emf_bk_long;
                d.cnt = emf_min_cyc(32'(`EMF_LONG_CYC), LONG_LIMIT_CYC);
              end
              `EMF_NOTICE_SLEEP: begin
                d.kind = emf_pkg::emf_bk_sleep;
                d.cnt = emf_min_cyc(32'(`EMF_SLEEP_CYC), SLEEP_LIMIT_CYC);
              end
              default: begin
                d.kind = emf_pkg::emf_bk_switch;
                d.cnt = 24'(`EMF_SWITCH_CYC);
              end
            endcase
          end
        end
      end
      if (cmd_idx == `EMF_CMD_SLEEP) begin
        if (cmd_arg[`EMF_SLEEP_ARG_BIT] && q.st == emf_pkg::emf_st_ready) begin
          d.st = emf_pkg::emf_st_sleep;
        end else if (!cmd_arg[`EMF_SLEEP_ARG_BIT] && q.st == emf_pkg::emf_st_sleep) begin
          d.st = emf_pkg::emf_st_ready;
          if (q.used) begin
            d.notice = `EMF_NOTICE_ON;
          end
        end
      end
      if (dl_cmd && q.mode == `EMF_MODE_UPDATE) begin
        if (cmd_arg != UPDATE_ARG) begin
          d.arg_bad = 1'b1;
        end else if (cmd_idx == `EMF_CMD_WR_SINGLE || cmd_idx == `EMF_CMD_WR_MULTI) begin
          d.dl = 1'b1;
          d.sectors = q.sectors + 16'h0001;
        end
      end
    end
    if (!reset_n) begin
      d = '0;
      d.hrs = 2'b11;
      d.st = emf_pkg::emf_st_ready;
      d.kind = emf_pkg::emf_bk_switch;
      d.notice = `EMF_NOTICE_NONE;
      d.mode = `EMF_MODE_NORMAL;
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign busy_core = q.st == emf_pkg::emf_st_busy;
  assign busy = busy_core;
  assign cache_enabled = q.cache_en;
  assign flush_active = q.flush;
  assign power_down_notice = q.notice;
  assign sleep_notice_busy_limit = SLEEP_NOTICE_TIME;
  assign in_field_code_update = q.mode == `EMF_MODE_UPDATE;
  assign fw_sectors_programmed = q.sectors;
  assign fw_install = q.install;
  assign fw_abort = q.abort;
  assign switch_error = q.sw_err;
  assign update_arg_error = q.arg_bad;
  assign sleeping = q.st == emf_pkg::emf_st_sleep;
  assign enhanced_area_kb = q.enh;
  assign max_enhanced_area_kb = q.enh_max;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  cache_off_reset_a: assert property (rst_ev |=> !cache_enabled && !flush_active)
    else $error("cache not off after reset event");

  flush_on_off_a: assert property (sw_ok && !rst_ev && sw_idx == `EMF_IDX_CACHE && q.cache_en &&
                                   !sw_new_cache[0] |=> (flush_active && busy) [*3])
    else $error("cache switch-off did not start a flush");

  zero_reject_a: assert property (sw_ok && !rst_ev && sw_idx == `EMF_IDX_NOTICE && q.used &&
                                  sw_new_notice == `EMF_NOTICE_NONE
                                  |=> switch_error && power_down_notice == $past(q.notice))
    else $error("zero notification write not rejected");

  notice_restore_a: assert property (restore_hit && !rst_ev && !sw_ok
                                     |=> power_down_notice == `EMF_NOTICE_ON)
    else $error("notification not restored to powered-on");

  wake_restore_a: assert property (sleeping && q.used && cmd_ev && !rst_ev &&
                                   cmd_idx == `EMF_CMD_SLEEP && !cmd_arg[`EMF_SLEEP_ARG_BIT]
                                   |=> !sleeping && power_down_notice == `EMF_NOTICE_ON)
    else $error("wake from sleep did not restore notification");

  short_bound_a: assert property (busy && q.kind == emf_pkg::emf_bk_short |-> q.run < GEN_LIMIT_CYC)
    else $error("short power-off busy beyond generic timeout");

  long_bound_a: assert property (busy && q.kind == emf_pkg::emf_bk_long |-> q.run < LONG_LIMIT_CYC)
    else $error("long power-off busy beyond its timeout");

  sleep_bound_a: assert property (busy && q.kind == emf_pkg::emf_bk_sleep
                                  |-> q.run < SLEEP_LIMIT_CYC)
    else $error("sleep notice busy beyond advertised limit");

  update_exit_a: assert property (sw_ok && !rst_ev && sw_idx == `EMF_IDX_MODE_CFG && q.dl &&
                                  sw_new_mode == `EMF_MODE_NORMAL
                                  |=> fw_abort ##1 !fw_abort && !in_field_code_update)
    else $error("leaving update mode did not abort download");

  switch_busy_a: assert property (sw_ok && !rst_ev && !restore_hit && sw_idx == `EMF_IDX_MODE_CFG
                                  |=> busy [*8] ##[1:20] !busy)
    else $error("mode write busy window wrong");

  arg_check_a: assert property (dl_cmd && !rst_ev && in_field_code_update && cmd_arg != UPDATE_ARG
                                |=> update_arg_error && $stable(fw_sectors_programmed))
    else $error("bad download argument not flagged");

  fw_install_a: assert property (rst_ev && !q.dl && q.sectors != 16'h0000
                              |=> fw_install && fw_sectors_programmed == 16'h0000)
    else $error("firmware not installed on reset");

endmodule // emf_mode_ctrl

`default_nettype wire

// *** emf_defines.svh ***
/*
  Constants of the managed flash mode control block: extended register byte
  indices, notification and mode codes, command indices and timing counts.
  Assumes a 100 ns core clock; included by every file that needs a figure.
*/
`ifndef EMF_DEFINES_SVH
`define EMF_DEFINES_SVH

`define EMF_IDX_MODE_CFG 8'h1e
`define EMF_IDX_CACHE 8'h21
`define EMF_IDX_NOTICE 8'h22
`define EMF_IDX_SLEEP_TIME 8'hd8

`define EMF_NOTICE_NONE 8'h00
`define EMF_NOTICE_ON 8'h01
`define EMF_NOTICE_SHORT 8'h02
`define EMF_NOTICE_LONG 8'h03
`define EMF_NOTICE_SLEEP 8'h04

`define EMF_MODE_NORMAL 8'h00
`define EMF_MODE_UPDATE 8'h01

`define EMF_ACC_SET 2'h1
`define EMF_ACC_CLR 2'h2
`define EMF_ACC_WRITE 2'h3

`define EMF_CMD_RESET 6'h00
`define EMF_CMD_SLEEP 6'h05
`define EMF_CMD_SWITCH 6'h06
`define EMF_CMD_SELECT 6'h07
`define EMF_CMD_RD_SINGLE 6'h11
`define EMF_CMD_RD_MULTI 6'h12
`define EMF_CMD_WR_SINGLE 6'h18
`define EMF_CMD_WR_MULTI 6'h19

`define EMF_SLEEP_ARG_BIT 15
`define EMF_FRAME_LAST 6'h2e
`define EMF_AREA_UNIT_KB 49'h200

`define EMF_CLK_NS 100
`define EMF_SWITCH_WORK_NS 2000
`define EMF_FLUSH_WORK_NS 20000
`define EMF_SHORT_WORK_NS 30000
`define EMF_LONG_WORK_NS 200000
`define EMF_SLEEP_WORK_NS 50000
`define EMF_TIMEOUT_UNIT_NS 10000000
`define EMF_SLEEP_UNIT_NS 10000
`define EMF_SWITCH_CYC ((`EMF_SWITCH_WORK_NS) / (`EMF_CLK_NS))
`define EMF_FLUSH_CYC ((`EMF_FLUSH_WORK_NS) / (`EMF_CLK_NS))
`define EMF_SHORT_CYC ((`EMF_SHORT_WORK_NS) / (`EMF_CLK_NS))
`define EMF_LONG_CYC ((`EMF_LONG_WORK_NS) / (`EMF_CLK_NS))
`define EMF_SLEEP_CYC ((`EMF_SLEEP_WORK_NS) / (`EMF_CLK_NS))
`define EMF_TIMEOUT_UNIT_CYC ((`EMF_TIMEOUT_UNIT_NS) / (`EMF_CLK_NS))
`define EMF_SLEEP_UNIT_CYC ((`EMF_SLEEP_UNIT_NS) / (`EMF_CLK_NS))

`endif

// *** emf_pkg.sv ***
/*
  Types of the managed flash mode control block: state encodings and the
  packed state records of the core and of the command link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package emf_pkg;

  typedef enum logic [2:0] {
    emf_st_ready = 3'b001,
    emf_st_busy = 3'b010,
    emf_st_sleep = 3'b100
  } emf_state_t;

  typedef enum logic [4:0] {
    emf_bk_switch = 5'b00001,
    emf_bk_flush = 5'b00010,
    emf_bk_short = 5'b00100,
    emf_bk_long = 5'b01000,
    emf_bk_sleep = 5'b10000
  } emf_busy_t;

  typedef struct packed {
    emf_state_t st;
    emf_busy_t kind;
    logic [2:0] tog;
    logic [1:0] hrs;
    logic [23:0] cnt;
    logic [31:0] run;
    logic cache_en;
    logic flush;
    logic [7:0] notice;
    logic used;
    logic [7:0] mode;
    logic dl;
    logic [15:0] sectors;
    logic sw_err;
    logic arg_bad;
    logic install;
    logic abort;
    logic [48:0] enh;
    logic [48:0] enh_max;
  } emf_core_t;

  typedef struct packed {
    logic [1:0] rs;
    logic [1:0] bs;
    logic rx;
    logic [5:0] cnt;
    logic [46:0] sh;
    logic [5:0] idx;
    logic [31:0] arg;
    logic tog;
  } emf_link_t;

endpackage

// *** emf_cmd_link.sv ***
/*
  Command line receiver and DAT0 busy driver, clocked by the host link clock.
  Assumes the host keeps the link clock running while it polls DAT0 busy and
  that successive command frames are spaced far apart compared to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "emf_defines.svh"

module emf_cmd_link (
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic cmd_i,
  input wire logic busy_core,
  output logic dat0_o,
  output logic dat0_oe,
  output logic [5:0] cmd_idx,
  output logic [31:0] cmd_arg,
  output logic cmd_tog
);

  emf_pkg::emf_link_t q;
  emf_pkg::emf_link_t d;

  // The received word is held stable until the next frame, so the core may
  // take it once the toggle has crossed through its synchroniser.
  always_comb begin
    d = q;
    d.rs = {q.rs[0], reset_n};
    d.bs = {q.bs[0], busy_core};
    if (!q.rx) begin
      if (!cmd_i) begin
        d.rx = 1'b1;
        d.cnt = 6'h00;
      end
    end else begin
      d.sh = {q.sh[45:0], cmd_i};
      d.cnt = q.cnt + 6'h01;
      if (q.cnt == `EMF_FRAME_LAST) begin
        d.rx = 1'b0;
        // The CRC is not checked; a frame needs a host direction bit and a stop bit.
        if (d.sh[46] && d.sh[0]) begin
          d.idx = d.sh[45:40];
          d.arg = d.sh[39:8];
          d.tog = ~q.tog;
        end
      end
    end
    if (!q.rs[1]) begin
      d.rx = 1'b0;
      d.cnt = 6'h00;
      d.sh = '0;
      d.idx = 6'h00;
      d.arg = 32'h0000_0000;
      d.tog = 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    q <= d;
  end

  assign dat0_o = 1'b0;
  assign dat0_oe = q.bs[1];
  assign cmd_idx = q.idx;
  assign cmd_arg = q.arg;
  assign cmd_tog = q.tog;

endmodule // emf_cmd_link

`default_nettype wire

// *** emf_host_model.sv ***
/*
  Host side model of the command link: sends whole command frames on the
  command line, one bit per link clock, and then keeps the line idle.
  Assumes the link clock runs freely and the command line idles high.
*/
`timescale 1ns/1ps
`default_nettype none

module emf_host_model (
  output var logic cmd_i,
  input wire logic link_clk
);
  initial cmd_i = 1'b1;

  // The check field is left zero, since the receiver does not check it.
  task automatic send(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] f;
    f = {1'b0, 1'b1, idx, arg, 7'h00, 1'b1};
    for (int i = 47; i >= 0; i--) begin
      @(negedge link_clk);
      cmd_i = f[i];
    end
    // Ten idle bits keep the next frame clear of the minimum gap.
    repeat (10) @(negedge link_clk);
  endtask
endmodule // emf_host_model

`default_nettype wire

// *** managed_flash_mode_control_bench.sv ***
/*
  Self-checking bench of the mode control core: a host model sends frames,
  the bench watches the state ports and the DAT0 line.
  Assumes the DAT0 line is pulled up wherever the device does not drive it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "emf_defines.svh"

module managed_flash_mode_control_bench;
  localparam logic [31:0] UARG = 32'h0000_0100;
  logic ref_clk, link_clk, reset_n, hw_rst_n, cmd_i, dat0_o, dat0_oe, dat0;
  logic [23:0] mult, mmax;
  logic [7:0] wp, er, v;
  logic busy, cache_en, flush, upd, inst, abrt, sw_err, arg_err, slp;
  logic [7:0] notice, slimit;
  logic [15:0] sectors;
  logic [48:0] area, area_max;
  int errors = 0;
  int tests_run = 0;
  int n_inst = 0;
  int n_abrt = 0;
  int seed = 41511;

  assign dat0 = dat0_oe ? dat0_o : 1'b1;

  emf_mode_ctrl #(.UPDATE_ARG(UARG), .SLEEP_NOTICE_TIME(8'h03)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .hw_rst_n(hw_rst_n), .link_clk(link_clk),
    .cmd_i(cmd_i), .dat0_o(dat0_o), .dat0_oe(dat0_oe), .enhanced_multiplier(mult),
    .max_enhanced_multiplier(mmax), .protect_group_size(wp), .erase_group_size(er),
    .busy(busy), .cache_enabled(cache_en), .flush_active(flush),
    .power_down_notice(notice), .sleep_notice_busy_limit(slimit),
    .in_field_code_update(upd), .fw_sectors_programmed(sectors), .fw_install(inst),
    .fw_abort(abrt), .switch_error(sw_err), .update_arg_error(arg_err),
    .sleeping(slp), .enhanced_area_kb(area), .max_enhanced_area_kb(area_max)
  );

  emf_host_model host (.cmd_i(cmd_i), .link_clk(link_clk));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // The link clock is offset so that its edges never meet the core clock edges.
  initial begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  // The install and abort outputs are one-cycle pulses, so they are counted.
  always @(negedge ref_clk) begin
    if (inst === 1'b1) n_inst++;
    if (abrt === 1'b1) n_abrt++;
  end

  task automatic print_verdict();
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [48:0] area_of(input logic [23:0] m, input logic [7:0] w,
                                         input logic [7:0] e);
    return 49'(m) * 49'(w) * 49'(e) * `EMF_AREA_UNIT_KB;
  endfunction

  task automatic sw(input logic [7:0] idx, input logic [7:0] val, input logic expb);
    host.send(`EMF_CMD_SWITCH, {6'h00, `EMF_ACC_WRITE, idx, val, 8'h00});
    chk(busy, expb);
    chk(!dat0, expb);
  endtask

  // Waits for busy and DAT0 to be released; overrunning max is a mismatch.
  task automatic idle(input int max);
    int n;
    n = 0;
    while (busy !== 1'b0 || dat0 !== 1'b1) begin
      n++;
      if (n > max) begin
        errors++;
        print_verdict();
      end
      @(negedge ref_clk);
    end
  endtask

  initial begin
    #5000000;
    errors++;
    print_verdict();
  end

  initial begin
    reset_n = 1'b0;
    hw_rst_n = 1'b1;
    {mult, mmax, wp, er} = '0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(cache_en, 1'b0);
    chk(slimit, 8'h03);
    for (int i = 0; i < 6; i++) begin
      mult = (i == 0) ? 24'hffffff : (i == 1) ? 24'h000000 : 24'($random(seed));
      mmax = (i == 0) ? 24'hffffff : 24'($random(seed));
      wp = (i == 0) ? 8'hff : 8'($random(seed));
      er = (i == 0) ? 8'hff : 8'($random(seed));
      repeat (2) @(negedge ref_clk);
      chk(area, area_of(mult, wp, er));
      chk(area_max, area_of(mmax, wp, er));
    end
    sw(`EMF_IDX_NOTICE, `EMF_NOTICE_ON, 1'b1);
    idle(40);
    chk(notice, `EMF_NOTICE_ON);
    sw(`EMF_IDX_NOTICE, `EMF_NOTICE_NONE, 1'b0);
    chk({sw_err, notice}, {1'b1, `EMF_NOTICE_ON});
    v = 8'($random(seed));
    sw(`EMF_IDX_CACHE, v | 8'h01, 1'b1);
    idle(40);
    chk({cache_en, sw_err}, 2'b10);
    sw(`EMF_IDX_CACHE, v & 8'hfe, 1'b1);
    chk({cache_en, flush}, 2'b01);
    idle(220);
    chk(flush, 1'b0);
    sw(`EMF_IDX_NOTICE, `EMF_NOTICE_SHORT, 1'b1);
    chk(notice, `EMF_NOTICE_SHORT);
    idle(330);
    host.send(`EMF_CMD_SELECT, 32'h0001_0000);
    chk(notice, `EMF_NOTICE_ON);
    sw(`EMF_IDX_NOTICE, `EMF_NOTICE_LONG, 1'b1);
    host.send(6'h0d, 32'h0);
    idle(40);
    chk(notice, `EMF_NOTICE_ON);
    sw(`EMF_IDX_NOTICE, `EMF_NOTICE_SLEEP, 1'b1);
    idle(800);
    host.send(`EMF_CMD_SELECT, 32'h0);
    chk(notice, `EMF_NOTICE_SLEEP);
    host.send(`EMF_CMD_SLEEP, 32'h0000_8000);
    chk(slp, 1'b1);
    host.send(`EMF_CMD_SLEEP, 32'h0);
    chk({slp, notice}, {1'b0, `EMF_NOTICE_ON});
    sw(`EMF_IDX_CACHE, 8'h01, 1'b1);
    idle(40);
    chk(upd, 1'b0);
    sw(`EMF_IDX_MODE_CFG, `EMF_MODE_UPDATE, 1'b1);
    idle(40);
    chk(upd, 1'b1);
    host.send(`EMF_CMD_WR_SINGLE, UARG);
    chk(sectors, 16'h0001);
    host.send(`EMF_CMD_RD_SINGLE, UARG ^ 32'h1);
    chk(arg_err, 1'b1);
    sw(`EMF_IDX_MODE_CFG, `EMF_MODE_NORMAL, 1'b1);
    idle(40);
    chk({upd, 8'(n_abrt)}, {1'b0, 8'h01});
    host.send(`EMF_CMD_RESET, 32'h0);
    chk(n_inst, 1);
    chk({cache_en, arg_err, sectors}, 18'h0);
    sw(`EMF_IDX_MODE_CFG, `EMF_MODE_UPDATE, 1'b1);
    idle(40);
    chk(sectors, 16'h0000);
    host.send(`EMF_CMD_WR_MULTI, UARG);
    host.send(`EMF_CMD_RESET, 32'h0);
    chk({8'(n_abrt), 8'(n_inst)}, 16'h0201);
    sw(`EMF_IDX_CACHE, 8'h01, 1'b1);
    idle(40);
    hw_rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    hw_rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk(cache_en, 1'b0);
    print_verdict();
  end
endmodule // managed_flash_mode_control_bench

`default_nettype wire
